// ===== bench/cfs_can_node.sv
// Remote bus nodes handing received frame identifiers to the filters
`timescale 1ns/1ps
`default_nettype none
module cfs_can_node (
  input wire core_clk,
  output logic frame_valid = 1'b0,
  output logic [10:0] frame_std_ident = 11'h000,
  output logic [17:0] frame_ext_ident = 18'h0_0000,
  output logic frame_is_ext = 1'b0
);
  task automatic send(logic [10:0] s, logic [17:0] e, logic x);
    @(posedge core_clk);
    frame_valid <= 1'b1;
    frame_std_ident <= s;
    frame_ext_ident <= e;
    frame_is_ext <= x;
    @(posedge core_clk);
    frame_valid <= 1'b0;
    // Stale identifiers never repeat the last frame
    frame_std_ident <= ~s;
    frame_ext_ident <= ~e;
    frame_is_ext <= ~x;
  endtask
endmodule
`default_nettype wire

// ===== bench/cfs_filter_stamp_status_asserts.sv
// Port checks for the filter, stamp and status block
`timescale 1ns/1ps
`default_nettype none
module cfs_fss_asserts #(parameter NUM_FIFO = 32) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_write,
  input wire reg_read,
  input wire [31:0] reg_rdata,
  input wire [NUM_FIFO-1:0] fifo_irq_pending,
  input wire [NUM_FIFO-1:0] rx_overflow_flag,
  input wire frame_valid,
  input wire frame_store,
  input wire [4:0] frame_fifo,
  input wire [15:0] stamp_count_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0000_0000) else $error("idle");
  a_unmapped_zero: assert property (reg_read && reg_addr > 8'h47 |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped");
  a_pend_mirror: assert property (reg_read && reg_addr == 8'h00 && $stable(fifo_irq_pending)
    |=> reg_rdata == $past(fifo_irq_pending)) else $error("pending");
  a_ovf_mirror: assert property (reg_read && reg_addr == 8'h04 && $stable(rx_overflow_flag)
    |=> reg_rdata == $past(rx_overflow_flag)) else $error("overflow");
  a_mask_gaps: assert property (reg_read && reg_addr inside {8'h0C, 8'h10, 8'h14}
    |=> reg_rdata[20] == 1'b0 && reg_rdata[18] == 1'b0) else $error("mask gap");
  a_store_cause: assert property (frame_store |-> $past(frame_valid)) else $error("store");
  a_fifo_hold: assert property (!frame_valid |=> $stable(frame_fifo)) else $error("fifo");
  a_stamp_step: assert property (!$stable(stamp_count_out) && !$past(reg_write, 2) &&
    !$past(reg_write) |-> stamp_count_out == $past(stamp_count_out) + 16'h0001) else $error("stamp");
endmodule
bind cfs_filter_stamp_status cfs_fss_asserts #(.NUM_FIFO(NUM_FIFO)) cfs_fss_asserts_inst (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .fifo_irq_pending(fifo_irq_pending),
  .rx_overflow_flag(rx_overflow_flag), .frame_valid(frame_valid), .frame_store(frame_store),
  .frame_fifo(frame_fifo), .stamp_count_out(stamp_count_out));
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the filter, stamp and status block
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defines.vh"
module tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, fv, ext, store, fx;
  logic [7:0] addr = 8'h00, hitv;
  logic [31:0] wd = 32'h0000_0000, rdata, pend = 32'h0000_0000, ovf = 32'h0000_0000;
  logic [10:0] std_ident_bits, fs;
  logic [17:0] ext_ident_bits, fe;
  logic [15:0] stamp;
  logic [31:0] mk [0:2], fid [0:7], fc [0:1];
  int bad_count = 0, n_tests = 0, cyc = 0, c0, k, h;
  always #12.5 core_clk = ~core_clk;
  cfs_can_node cfs_can_node_inst (.core_clk(core_clk), .frame_valid(fv), .frame_std_ident(std_ident_bits),
    .frame_ext_ident(ext_ident_bits), .frame_is_ext(ext));
  cfs_filter_stamp_status cfs_filter_stamp_status_inst (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(addr), .reg_wdata(wd), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
    .op_state(3'h4), .fifo_irq_pending(pend), .rx_overflow_flag(ovf), .frame_valid(fv),
    .frame_std_ident(std_ident_bits), .frame_ext_ident(ext_ident_bits), .frame_is_ext(ext), .frame_store(store),
    .frame_fifo(hitv[7:3]), .frame_filter(hitv[2:0]), .stamp_count_out(stamp));
  task automatic chk(logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %0t: %h not %h", $time, seen, exp);
    end
  endtask
  // Write when w is set, otherwise read and compare with d
  task automatic acc(logic w, int a, logic [31:0] d);
    @(posedge core_clk);
    wr <= w;
    rd <= !w;
    addr <= a[7:0];
    wd <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    if (!w) #1 chk(rdata, d);
  endtask
  function automatic int hit(logic [10:0] s, logic [17:0] e, logic x);
    logic [7:0] b;
    logic [31:0] m;
    for (int i = 0; i < 8; i++) begin
      b = fc[i / 4][8 * (i % 4) +: 8];
      m = (b[6:5] == 2'd3) ? 32'h0000_0000 : mk[b[6:5]];
      if (b[7] && !(m[19] && fid[i][19] != x) && ((s ^ fid[i][31:21]) & m[31:21]) == 11'h000 &&
          (!x || ((e ^ fid[i][17:0]) & m[17:0]) == 18'h0_0000)) return i;
    end
    return -1;
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict;
    end
  end
  initial begin
    c0 = $urandom(32'ha827_5654);
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    h = $urandom;
    c0 = $urandom;
    pend <= h;
    ovf <= c0;
    acc(1'b0, `CFS_OFF_PENDING, h);
    acc(1'b0, `CFS_OFF_OVERFLOW, c0);
    acc(1'b0, 8'h80, 32'h0000_0000);
    $display("status test done");
    acc(1'b1, `CFS_OFF_TIMER, 32'h0005_0004);
    acc(1'b0, `CFS_OFF_TIMER, 32'h0005_0004);
    acc(1'b1, `CFS_OFF_CONTROL, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    #1 c0 = stamp;
    repeat (40) @(posedge core_clk);
    #1 chk(stamp, c0 + 10);
    $display("timer test done");
    for (int t = 0; t < 3; t++) begin
      acc(1'b1, `CFS_OFF_FLTCON0, 32'h0000_0000);
      acc(1'b1, `CFS_OFF_FLTCON1, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
        fid[i] = $urandom;
        acc(1'b1, `CFS_OFF_FILTER0 + 4 * i, fid[i]);
        if (i < 3) mk[i] = $urandom;
        if (i < 3) acc(1'b1, `CFS_OFF_MASK0 + 4 * i, mk[i]);
        if (i < 3) acc(1'b0, `CFS_OFF_MASK0 + 4 * i, mk[i] & `CFS_MASK_IMPL);
      end
      for (int i = 0; i < 2; i++) begin
        fc[i] = $urandom;
        acc(1'b1, `CFS_OFF_FLTCON0 + 4 * i, fc[i]);
      end
      for (int n = 0; n < 80; n++) begin
        k = $urandom % 8;
        h = $urandom;
        fx = h[31];
        if (n % 3 == 0) h = 0;
        fs = fid[k][31:21] ^ h[10:0];
        fe = fid[k][17:0] ^ h[28:11];
        c0 = hit(fs, fe, fx);
        cfs_can_node_inst.send(fs, fe, fx);
        #1 chk(store, c0 >= 0);
        if (c0 >= 0) chk(hitv, {fc[c0 / 4][8 * (c0 % 4) +: 5], c0[2:0]});
        if (c0 >= 0) acc(1'b0, `CFS_OFF_HIT, {28'd0, 1'b1, c0[2:0]});
      end
    end
    $display("filter test done");
    print_verdict;
  end
endmodule
`default_nettype wire

// ===== hdl/cfs_defines.vh
// Register offsets, field positions, reset values and the configuration mode code for the filter/stamp/status block
`ifndef CFS_DEFINES_VH
`define CFS_DEFINES_VH

// ***************
// Register offsets
// ***************
`define CFS_OFF_PENDING 8'h00
`define CFS_OFF_OVERFLOW 8'h04
`define CFS_OFF_TIMER 8'h08
`define CFS_OFF_MASK0 8'h0C
`define CFS_OFF_MASK1 8'h10
`define CFS_OFF_MASK2 8'h14
`define CFS_OFF_FLTCON0 8'h18
`define CFS_OFF_FLTCON1 8'h1C
`define CFS_OFF_FILTER0 8'h20
`define CFS_OFF_FILTER7 8'h3C
`define CFS_OFF_CONTROL 8'h40
`define CFS_OFF_HIT 8'h44

// ***************
// Field positions
// ***************
`define CFS_SID_HI 31
`define CFS_SID_LO 21
`define CFS_TYPE_BIT 19
`define CFS_EID_HI 17
`define CFS_STAMP_HI 31
`define CFS_STAMP_LO 16
`define CFS_PRE_HI 15
`define CFS_FLT_EN 7
`define CFS_MASK_CHOICE_HI 6
`define CFS_MASK_CHOICE_LO 5
`define CFS_FIFO_CHOICE_HI 4
`define CFS_MASK_IMPL 32'hFFEB_FFFF
`define CFS_FILT_IMPL 32'hFFEB_FFFF
`define CFS_CONFIG_MODE 3'h4

// ***************
// Reset values
// ***************
`define CFS_RST_WORD 32'h0000_0000
`define CFS_RST_HALF 16'h0000

`endif

// ===== hdl/cfs_filter_stamp_status.v
// Acceptance filtering, timestamp timer and per-FIFO status of a CAN controller
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defines.vh"

module cfs_filter_stamp_status #(
  parameter NUM_FIFO = 32,
  parameter NUM_FILT = 8
) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  input wire [2:0] op_state,
  input wire [NUM_FIFO-1:0] fifo_irq_pending,
  input wire [NUM_FIFO-1:0] rx_overflow_flag,
  input wire frame_valid,
  input wire [10:0] frame_std_ident,
  input wire [17:0] frame_ext_ident,
  input wire frame_is_ext,
  output reg frame_store,
  output reg [4:0] frame_fifo,
  output reg [2:0] frame_filter,
  output reg [15:0] stamp_count_out
);

  // ***************
  // Register state
  // ***************
  reg [31:0] pending_status;
  reg [31:0] overflow_status;
  reg [15:0] stamp_count;
  reg [15:0] stamp_prescale;
  reg [15:0] pre_count;
  reg stamp_capture_enable;
  reg [31:0] mask_reg [0:2];
  reg [31:0] filt_reg [0:NUM_FILT-1];
  reg [31:0] fltcon [0:1];
  reg [3:0] hit_info;
  reg [31:0] next_rdata;
  integer i;

  // Mask word chosen by a two-bit select; mask 3 has no register
  function [31:0] mask_of;
    input [1:0] sel;
    input [31:0] m0;
    input [31:0] m1;
    input [31:0] m2;
    begin
      case (sel)
        2'd0: mask_of = m0;
        2'd1: mask_of = m1;
        2'd2: mask_of = m2;
        default: mask_of = `CFS_RST_WORD;
      endcase
    end
  endfunction

  // One filter's compare against the presented frame
  function filt_match;
    input [31:0] mask;
    input [31:0] fid;
    input [10:0] std_ident_bits;
    input [17:0] ext_ident_bits;
    input is_ext;
    reg [10:0] sid_miss;
    reg [17:0] eid_miss;
    begin
      sid_miss = (std_ident_bits ^ fid[`CFS_SID_HI:`CFS_SID_LO]) & mask[`CFS_SID_HI:`CFS_SID_LO];
      eid_miss = (ext_ident_bits ^ fid[`CFS_EID_HI:0]) & mask[`CFS_EID_HI:0];
      if (mask[`CFS_TYPE_BIT]) begin
        // Type must agree; extended frames also compare the extended part
        filt_match = (is_ext == fid[`CFS_TYPE_BIT]) && (sid_miss == 11'd0) &&
          (!is_ext || eid_miss == 18'd0);
      end else begin
        // Either frame type passes if its identifier agrees
        filt_match = (sid_miss == 11'd0) && (!is_ext || eid_miss == 18'd0);
      end
    end
  endfunction

  // ***************
  // Filter decode
  // ***************
  wire [NUM_FILT-1:0] hit;
  wire [7:0] ctl [0:NUM_FILT-1];
  genvar g;
  generate
    for (g = 0; g < NUM_FILT; g = g + 1) begin : g_filt
      assign ctl[g] = fltcon[g/4][(g%4)*8+7:(g%4)*8];
      assign hit[g] = ctl[g][`CFS_FLT_EN] &&
        filt_match(mask_of(ctl[g][`CFS_MASK_CHOICE_HI:`CFS_MASK_CHOICE_LO], mask_reg[0], mask_reg[1],
          mask_reg[2]), filt_reg[g], frame_std_ident, frame_ext_ident, frame_is_ext);
    end
  endgenerate

  // Lowest accepting filter wins
  reg next_store;
  reg [4:0] next_fifo;
  reg [2:0] next_filter;
  always @* begin
    next_store = 1'b0;
    next_fifo = 5'd0;
    next_filter = 3'd0;
    for (i = NUM_FILT - 1; i >= 0; i = i - 1) begin
      if (frame_valid && hit[i]) begin
        next_store = 1'b1;
        next_fifo = ctl[i][`CFS_FIFO_CHOICE_HI:0];
        next_filter = i[2:0];
      end
    end
  end

  // ***************
  // Address decode
  // ***************
  // Word-aligned filter identifier window
  function is_filt_addr;
    input [7:0] a;
    begin
      is_filt_addr = (a >= `CFS_OFF_FILTER0) && (a <= `CFS_OFF_FILTER7) &&
        (a[1:0] == 2'b00);
    end
  endfunction

  wire wr_timer = reg_write && (reg_addr == `CFS_OFF_TIMER);
  wire wr_control = reg_write && (reg_addr == `CFS_OFF_CONTROL);
  wire wr_fltcon0 = reg_write && (reg_addr == `CFS_OFF_FLTCON0);
  wire wr_fltcon1 = reg_write && (reg_addr == `CFS_OFF_FLTCON1);
  wire wr_filt = reg_write && is_filt_addr(reg_addr);
  wire [2:0] wr_filt_idx = reg_addr[4:2];
  wire [2:0] wr_mask;
  assign wr_mask[0] = reg_write && (reg_addr == `CFS_OFF_MASK0);
  assign wr_mask[1] = reg_write && (reg_addr == `CFS_OFF_MASK1);
  assign wr_mask[2] = reg_write && (reg_addr == `CFS_OFF_MASK2);
  wire pre_done = (pre_count + 16'd1) >= stamp_prescale;
  reg in_config;
  integer j;
  integer k;

  // ***************
  // FIFO status mirrors
  // ***************
  // Levels come from FIFO logic on this clock; cleared there, not here
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pending_status <= `CFS_RST_WORD;
      overflow_status <= `CFS_RST_WORD;
    end else begin
      pending_status <= fifo_irq_pending;
      overflow_status <= rx_overflow_flag;
    end
  end

  // ***************
  // Acceptance result
  // ***************
  // Destination and filter number hold until the next accepted frame
  always @(posedge core_clk) begin
    if (!rst_n) begin
      frame_store <= 1'b0;
      frame_fifo <= 5'd0;
      frame_filter <= 3'd0;
      hit_info <= 4'd0;
    end else begin
      frame_store <= next_store;
      if (next_store) begin
        frame_fifo <= next_fifo;
        frame_filter <= next_filter;
        hit_info <= {1'b1, next_filter};
      end
    end
  end

  // ***************
  // Timestamp timer
  // ***************
  // A write restarts the interval so the first step after it is a full one
  always @(posedge core_clk) begin
    if (!rst_n) begin
      stamp_count <= `CFS_RST_HALF;
      stamp_prescale <= `CFS_RST_HALF;
      pre_count <= `CFS_RST_HALF;
    end else if (wr_timer) begin
      stamp_count <= reg_wdata[`CFS_STAMP_HI:`CFS_STAMP_LO];
      stamp_prescale <= reg_wdata[`CFS_PRE_HI:0];
      pre_count <= `CFS_RST_HALF;
    end else if (stamp_capture_enable) begin
      if (pre_done) begin
        pre_count <= `CFS_RST_HALF;
        stamp_count <= stamp_count + 16'd1;
      end else begin
        pre_count <= pre_count + 16'd1;
      end
    end
  end

  // Copy for the port, one cycle behind the counter
  always @(posedge core_clk) begin
    if (!rst_n) begin
      stamp_count_out <= `CFS_RST_HALF;
    end else begin
      stamp_count_out <= stamp_count;
    end
  end

  // ***************
  // Control register
  // ***************
  // Capture enable gates both timer counts
  always @(posedge core_clk) begin
    if (!rst_n) begin
      stamp_capture_enable <= 1'b0;
    end else if (wr_control) begin
      stamp_capture_enable <= reg_wdata[0];
    end
  end

  // Configuration mode seen by software before touching masks
  always @(posedge core_clk) begin
    if (!rst_n) begin
      in_config <= 1'b0;
    end else begin
      in_config <= (op_state == `CFS_CONFIG_MODE);
    end
  end

  // ***************
  // Masks and filter controls
  // ***************
  // Mode and enable restrictions are software duties; writes are not blocked
  always @(posedge core_clk) begin
    if (!rst_n) begin
      for (j = 0; j < 3; j = j + 1) begin
        mask_reg[j] <= `CFS_RST_WORD;
      end
    end else begin
      for (j = 0; j < 3; j = j + 1) begin
        if (wr_mask[j]) begin
          mask_reg[j] <= reg_wdata & `CFS_MASK_IMPL;
        end
      end
    end
  end

  // Filter identifier words; gap bits stay zero
  always @(posedge core_clk) begin
    if (!rst_n) begin
      for (k = 0; k < NUM_FILT; k = k + 1) begin
        filt_reg[k] <= `CFS_RST_WORD;
      end
    end else if (wr_filt) begin
      filt_reg[wr_filt_idx] <= reg_wdata & `CFS_FILT_IMPL;
    end
  end

  // Four filters per control word
  always @(posedge core_clk) begin
    if (!rst_n) begin
      fltcon[0] <= `CFS_RST_WORD;
      fltcon[1] <= `CFS_RST_WORD;
    end else begin
      if (wr_fltcon0) begin
        fltcon[0] <= reg_wdata;
      end
      if (wr_fltcon1) begin
        fltcon[1] <= reg_wdata;
      end
    end
  end

  // ***************
  // Read path
  // ***************
  always @* begin
    next_rdata = `CFS_RST_WORD;
    case (reg_addr)
      `CFS_OFF_PENDING: next_rdata = pending_status;
      `CFS_OFF_OVERFLOW: next_rdata = overflow_status;
      `CFS_OFF_TIMER: next_rdata = {stamp_count, stamp_prescale};
      `CFS_OFF_MASK0: next_rdata = mask_reg[0];
      `CFS_OFF_MASK1: next_rdata = mask_reg[1];
      `CFS_OFF_MASK2: next_rdata = mask_reg[2];
      `CFS_OFF_FLTCON0: next_rdata = fltcon[0];
      `CFS_OFF_FLTCON1: next_rdata = fltcon[1];
      `CFS_OFF_CONTROL: next_rdata = {30'd0, in_config, stamp_capture_enable};
      `CFS_OFF_HIT: next_rdata = {28'd0, hit_info};
      default: begin
        if (is_filt_addr(reg_addr)) begin
          next_rdata = filt_reg[reg_addr[4:2]];
        end
      end
    endcase
  end

  // Read data stand one cycle, zero otherwise
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= `CFS_RST_WORD;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `CFS_RST_WORD;
    end
  end

endmodule
`default_nettype wire
